// ==== pp_pkg.sv ====
// Package with register map, bit positions, reset values and timing counts of the port
`default_nettype none

package pp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus geometry: register offsets are word indices, byte address is four times
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int IDX_W = 3;
    localparam logic [2:0] IDX_DATA = 3'h0;
    localparam logic [2:0] IDX_STATUS = 3'h1;
    localparam logic [2:0] IDX_CTRL = 3'h2;
    localparam logic [2:0] IDX_IRQ_STAT = 3'h3;
    localparam logic [2:0] IDX_IRQ_MASK = 3'h4;

    ////////////////////////////////////////////////////////////////////////////////
    // Status buffer bit positions
    localparam int ST_BUSY = 7;
    localparam int ST_ACK_N = 6;
    localparam int ST_PAPER_END = 5;
    localparam int ST_SELECTED = 4;
    localparam int ST_ERROR_N = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Control latch bit positions and values
    localparam int CT_STROBE = 0;
    localparam int CT_AUTOFEED = 1;
    localparam int CT_INIT_N = 2;
    localparam int CT_SELECT_IN = 3;
    localparam int CT_ACK_IRQ_EN = 4;
    localparam int CT_DIR_IN = 5;
    localparam int CTRL_W = 6;
    localparam logic [5:0] CTRL_RESET = 6'h04;
    localparam logic [5:0] CTRL_RD_MASK = 6'h1F;
    localparam logic [7:0] DATA_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status bits
    localparam int IRQ_W = 2;
    localparam int IRQ_ACK_RISE = 0;
    localparam int IRQ_ERROR = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing: least times round up to whole clock cycles
    localparam int CLK_PERIOD_NS = 8;
    localparam int STROBE_MIN_NS = 500;
    localparam int INIT_MIN_US = 50;
    localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_MIN_CYC = (INIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CNT_W = $clog2(STROBE_MIN_CYC + 1);
    localparam int LEN_W = 16;

    typedef enum logic {PP_BUS_IDLE, PP_BUS_ANSWER} pp_bus_state_t;

endpackage : pp_pkg

`default_nettype wire

// ==== pp_reg_if.sv ====
// Interface carrying register accesses from the bus slave to the register file
`timescale 1ns/1ns
`default_nettype none

interface pp_reg_if;
    logic wr;
    logic [2:0] idx;
    logic [7:0] wdata;
    logic be;
    logic [7:0] rdata;
    modport bus (output wr, output idx, output wdata, output be, input rdata);
    modport regs (input wr, input idx, input wdata, input be, output rdata);
endinterface : pp_reg_if

`default_nettype wire

// ==== pp_regbus.sv ====
// Avalon-MM slave with one wait state, feeding the register file
`timescale 1ns/1ns
`default_nettype none

module pp_regbus (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [pp_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [pp_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [pp_pkg::BE_W-1:0] avs_byteenable_i,
    output logic [pp_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    pp_reg_if.bus regs
);

    pp_pkg::pp_bus_state_t state;
    wire logic req = avs_read_i | avs_write_i;
    wire logic in_answer = (state == pp_pkg::PP_BUS_ANSWER);

    // Writes land at the edge where the master sees waitrequest low
    assign regs.wr = avs_write_i & in_answer;
    assign regs.idx = avs_address_i[pp_pkg::ADDR_W-1:2];
    assign regs.wdata = avs_writedata_i[7:0];
    assign regs.be = avs_byteenable_i[0];

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state <= pp_pkg::PP_BUS_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
        end else begin
            unique case (state)
                pp_pkg::PP_BUS_IDLE: begin
                    if (req) begin
                        state <= pp_pkg::PP_BUS_ANSWER;
                        avs_waitrequest_o <= 1'b0;
                        avs_readdata_o <= avs_read_i ? {24'h000000, regs.rdata} : 32'h00000000;
                    end
                end
                pp_pkg::PP_BUS_ANSWER: begin
                    state <= pp_pkg::PP_BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

endmodule : pp_regbus

`default_nettype wire

// ==== pp_irq.sv ====
// Sticky interrupt status with write-one-to-clear, mask and one level output
`timescale 1ns/1ns
`default_nettype none

module pp_irq #(
    parameter int N = 2
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [N-1:0] event_i,
    input wire logic clr_we_i,
    input wire logic mask_we_i,
    input wire logic [N-1:0] wdata_i,
    output logic [N-1:0] status_o,
    output logic [N-1:0] mask_o,
    output logic irq_o
);

    // Set beats clear so an event in the clearing cycle survives
    wire logic [N-1:0] clr_bits = clr_we_i ? wdata_i : '0;
    wire logic [N-1:0] next_status = (status_o & ~clr_bits) | event_i;
    wire logic [N-1:0] next_mask = mask_we_i ? wdata_i : mask_o;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            status_o <= '0;
            mask_o <= '0;
            irq_o <= 1'b0;
        end else begin
            status_o <= next_status;
            mask_o <= next_mask;
            irq_o <= |(next_status & next_mask);
        end
    end

endmodule : pp_irq

`default_nettype wire

// ==== pp_top.sv ====
// Byte-wide printer port: registers, pin drivers, pulse stretchers and interrupts
//
// Notes on behaviour
// - Data read in output mode returns the output latch, not the pins.
// - Data at index 0, status at index 1, control at index 2.
// - Status bit 7 shows busy; host sends no strobe while busy; here pp_strobe_o is not gated by pp_busy_i.
// - Status bit 6 shows live acknowledge level; zero means byte taken.
// - Status bit 5 reads one when paper has run out.
// - Status bit 4 reads one when peripheral is selected.
// - Status bit 3 reads zero on peripheral error, active low.
// - Control read returns the current control latch contents; here bit 5, the direction bit, reads zero.
// - Control bit 5 set releases data drivers for input; clear drives.
// - Control bit 4 enables interrupt on each acknowledge low-to-high edge.
// - Control bit 3 set asserts select-in toward the peripheral.
// - Control bit 2 zero asserts initialize, held fifty microseconds minimum.
// - Control bit 1 set asserts auto-feed for line advance.
// - Control bit 0 drives strobe, held half a microsecond minimum.
// - Eight-bit data path driven from the host-written output latch.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none

module pp_top #(
    parameter int INIT_MIN_CYC = pp_pkg::INIT_MIN_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [pp_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [pp_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [pp_pkg::BE_W-1:0] avs_byteenable_i,
    output logic [pp_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [7:0] pp_data_i,
    output logic [7:0] pp_data_o,
    output logic pp_data_oe_o,
    output logic pp_strobe_o,
    output logic pp_autofeed_o,
    output logic pp_init_o,
    output logic pp_select_in_o,
    input wire logic pp_busy_i,
    input wire logic pp_ack_n_i,
    input wire logic pp_paper_end_i,
    input wire logic pp_selected_i,
    input wire logic pp_error_n_i,
    output logic irq_o
);

    localparam int INIT_CNT_W = $clog2(INIT_MIN_CYC + 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave
    pp_reg_if reg_bus ();

    pp_regbus u_regbus (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .regs(reg_bus.bus)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] out_latch;
    logic [pp_pkg::CTRL_W-1:0] ctrl;
    logic ack_n_prev;
    logic error_n_prev;
    logic [pp_pkg::STROBE_CNT_W-1:0] strobe_cnt;
    logic [INIT_CNT_W-1:0] init_cnt;
    logic [pp_pkg::IRQ_W-1:0] irq_stat;
    logic [pp_pkg::IRQ_W-1:0] irq_mask;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode
    wire logic wr_ok = reg_bus.wr & reg_bus.be;
    wire logic data_we = wr_ok & (reg_bus.idx == pp_pkg::IDX_DATA);
    wire logic ctrl_we = wr_ok & (reg_bus.idx == pp_pkg::IDX_CTRL);
    wire logic irq_clr_we = wr_ok & (reg_bus.idx == pp_pkg::IDX_IRQ_STAT);
    wire logic irq_mask_we = wr_ok & (reg_bus.idx == pp_pkg::IDX_IRQ_MASK);
    // Bits 7:6 of a control write are dropped here
    wire logic [pp_pkg::CTRL_W-1:0] next_ctrl = reg_bus.wdata[pp_pkg::CTRL_W-1:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux
    wire logic dir_in = ctrl[pp_pkg::CT_DIR_IN];
    // Input mode shows the pins; output mode shows the latch so undriven lines never leak
    wire logic [7:0] data_rd = dir_in ? pp_data_i : out_latch;
    wire logic [7:0] status_rd = {pp_busy_i, pp_ack_n_i, pp_paper_end_i, pp_selected_i,
                                  pp_error_n_i, 3'h0};
    // Direction bit is write-only and reads zero
    wire logic [7:0] ctrl_rd = {2'h0, ctrl & pp_pkg::CTRL_RD_MASK};
    wire logic [7:0] irq_stat_rd = {6'h00, irq_stat};
    wire logic [7:0] irq_mask_rd = {6'h00, irq_mask};

    assign reg_bus.rdata = (reg_bus.idx == pp_pkg::IDX_DATA) ? data_rd :
                           (reg_bus.idx == pp_pkg::IDX_STATUS) ? status_rd :
                           (reg_bus.idx == pp_pkg::IDX_CTRL) ? ctrl_rd :
                           (reg_bus.idx == pp_pkg::IDX_IRQ_STAT) ? irq_stat_rd :
                           (reg_bus.idx == pp_pkg::IDX_IRQ_MASK) ? irq_mask_rd :
                           8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Latches
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            out_latch <= pp_pkg::DATA_RESET;
        end else if (data_we) begin
            out_latch <= reg_bus.wdata;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl <= pp_pkg::CTRL_RESET;
        end else if (ctrl_we) begin
            ctrl <= next_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse stretchers: a short software pulse still meets the peripheral's minimum
    wire logic strobe_start = ctrl_we & next_ctrl[pp_pkg::CT_STROBE] & ~ctrl[pp_pkg::CT_STROBE];
    wire logic init_start = ctrl_we & ~next_ctrl[pp_pkg::CT_INIT_N] & ctrl[pp_pkg::CT_INIT_N];
    wire logic strobe_busy = (strobe_cnt != '0);
    wire logic init_busy = (init_cnt != '0);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            strobe_cnt <= '0;
        end else if (strobe_start) begin
            strobe_cnt <= pp_pkg::STROBE_CNT_W'(pp_pkg::STROBE_MIN_CYC);
        end else if (strobe_busy) begin
            strobe_cnt <= strobe_cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            init_cnt <= '0;
        end else if (init_start) begin
            init_cnt <= INIT_CNT_W'(INIT_MIN_CYC);
        end else if (init_busy) begin
            init_cnt <= init_cnt - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers, all registered
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pp_data_o <= pp_pkg::DATA_RESET;
            pp_data_oe_o <= 1'b0;
            pp_strobe_o <= 1'b0;
            pp_autofeed_o <= 1'b0;
            pp_init_o <= 1'b0;
            pp_select_in_o <= 1'b0;
        end else begin
            pp_data_o <= out_latch;
            pp_data_oe_o <= ~dir_in;
            pp_strobe_o <= ctrl[pp_pkg::CT_STROBE] | strobe_busy;
            pp_autofeed_o <= ctrl[pp_pkg::CT_AUTOFEED];
            pp_init_o <= ~ctrl[pp_pkg::CT_INIT_N] | init_busy;
            pp_select_in_o <= ctrl[pp_pkg::CT_SELECT_IN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Events and interrupts
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ack_n_prev <= 1'b1;
            error_n_prev <= 1'b1;
        end else begin
            ack_n_prev <= pp_ack_n_i;
            error_n_prev <= pp_error_n_i;
        end
    end

    // Acknowledge edge gated by the enable bit; with the bit clear no acknowledge event is recorded at all
    wire logic ack_rise = pp_ack_n_i & ~ack_n_prev & ctrl[pp_pkg::CT_ACK_IRQ_EN];
    wire logic error_fall = ~pp_error_n_i & error_n_prev;
    wire logic [pp_pkg::IRQ_W-1:0] irq_events = {error_fall, ack_rise};

    pp_irq #(
        .N(pp_pkg::IRQ_W)
    ) u_irq (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .event_i(irq_events),
        .clr_we_i(irq_clr_we),
        .mask_we_i(irq_mask_we),
        .wdata_i(reg_bus.wdata[pp_pkg::IRQ_W-1:0]),
        .status_o(irq_stat),
        .mask_o(irq_mask),
        .irq_o(irq_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [pp_pkg::LEN_W-1:0] strobe_len;
    logic [pp_pkg::LEN_W-1:0] init_len;
    localparam int STROBE_NEED = pp_pkg::STROBE_MIN_CYC;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            strobe_len <= '0;
            init_len <= '0;
        end else begin
            strobe_len <= pp_strobe_o ? ((strobe_len == '1) ? strobe_len : strobe_len + 1'b1) : '0;
            init_len <= pp_init_o ? ((init_len == '1) ? init_len : init_len + 1'b1) : '0;
        end
    end

    wire logic rd_take = avs_read_i & avs_waitrequest_o;
    wire logic [2:0] rd_idx = avs_address_i[pp_pkg::ADDR_W-1:2];

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    AST_DATA_READBACK: assert property (
        rd_take && rd_idx == pp_pkg::IDX_DATA && !dir_in
        |=> !avs_waitrequest_o && avs_readdata_o == {24'h000000, $past(out_latch)})
        else $error("data read in output mode did not return the latch");

    AST_STATUS_BUSY: assert property (
        rd_take && rd_idx == pp_pkg::IDX_STATUS
        |=> avs_readdata_o[pp_pkg::ST_BUSY] == $past(pp_busy_i))
        else $error("status busy bit does not follow busy input");

    AST_STATUS_ACK: assert property (
        rd_take && rd_idx == pp_pkg::IDX_STATUS
        |=> avs_readdata_o[pp_pkg::ST_ACK_N] == $past(pp_ack_n_i))
        else $error("status acknowledge bit does not follow pin");

    AST_STATUS_LOW: assert property (
        rd_take && rd_idx == pp_pkg::IDX_STATUS
        |=> avs_readdata_o[5:0] == {$past(pp_paper_end_i), $past(pp_selected_i),
                                    $past(pp_error_n_i), 3'h0})
        else $error("status low bits wrong");

    AST_CTRL_READBACK: assert property (
        rd_take && rd_idx == pp_pkg::IDX_CTRL
        |=> avs_readdata_o == {27'h0000000, $past(ctrl[4:0])})
        else $error("control readback wrong");

    AST_DIR_OE: assert property (
        ctrl_we ##1 !ctrl_we |=> pp_data_oe_o == !$past(ctrl[pp_pkg::CT_DIR_IN]))
        else $error("data drivers do not follow direction bit");

    AST_ACK_IRQ: assert property (
        $rose(pp_ack_n_i) && ctrl[pp_pkg::CT_ACK_IRQ_EN] && irq_mask[pp_pkg::IRQ_ACK_RISE]
        |=> irq_stat[pp_pkg::IRQ_ACK_RISE] && irq_o)
        else $error("acknowledge edge did not raise interrupt");

    AST_NO_ACK_IRQ: assert property (
        !irq_stat[pp_pkg::IRQ_ACK_RISE] && !ctrl[pp_pkg::CT_ACK_IRQ_EN]
        |=> !irq_stat[pp_pkg::IRQ_ACK_RISE])
        else $error("acknowledge interrupt raised while disabled");

    AST_SELECT_IN: assert property (
        ##1 pp_select_in_o == $past(ctrl[pp_pkg::CT_SELECT_IN]))
        else $error("select-in does not follow control bit");

    AST_INIT_MIN: assert property (
        $fell(pp_init_o) |-> init_len >= INIT_MIN_CYC)
        else $error("initialize pulse shorter than minimum");

    AST_AUTOFEED: assert property (
        ##1 pp_autofeed_o == $past(ctrl[pp_pkg::CT_AUTOFEED]))
        else $error("auto-feed does not follow control bit");

    AST_STROBE_MIN: assert property (
        $fell(pp_strobe_o) |-> strobe_len >= STROBE_NEED)
        else $error("strobe pulse shorter than minimum");

    AST_DATA_OUT: assert property (
        data_we |=> ##1 pp_data_o == $past(reg_bus.wdata, 2))
        else $error("data pins do not carry written byte");

    AST_RESERVED: assert property (
        rd_take && (rd_idx == pp_pkg::IDX_STATUS || rd_idx == pp_pkg::IDX_CTRL)
        |=> avs_readdata_o[31:8] == 24'h000000)
        else $error("unused bits read non-zero");

    COV_ACK_IRQ: cover property ($rose(pp_ack_n_i) ##1 irq_o);
    COV_STROBE: cover property ($rose(pp_strobe_o) ##[1:200] $fell(pp_strobe_o));
    COV_INPUT_READ: cover property (rd_take && rd_idx == pp_pkg::IDX_DATA && dir_in);
    COV_CLR_RACE: cover property (irq_clr_we && |irq_events);

endmodule : pp_top

`default_nettype wire

// ==== pp_printer_model.sv ====
// Behavioural printer standing at the far side of the port
`timescale 1ns/1ns
`default_nettype none

module pp_printer_model #(
    parameter int BUSY_CYC = 700,
    parameter int ACK_CYC = 625
) (
    input wire logic clk_sys_i,
    input wire logic [7:0] host_data_i,
    input wire logic host_oe_i,
    input wire logic strobe_i,
    input wire logic drive_en_i,
    input wire logic [7:0] drive_val_i,
    output logic [7:0] pins_o,
    output logic busy_o,
    output logic ack_n_o,
    output logic [7:0] byte_o = 8'h00,
    output logic proto_err_o = 1'b0
);
    int cnt = 0;
    int stable = 0;
    logic strobe_d = 1'b0;
    logic [7:0] last = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Floating pins have no pull: show a pattern that flips every cycle
    assign pins_o = host_oe_i ? host_data_i : (drive_en_i ? drive_val_i : ~last);
    // Cycles the pins have held their value, for the setup check
    always @(posedge clk_sys_i) begin
        last <= pins_o;
        stable <= (pins_o === last) ? stable + 1 : 0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Busy from the strobe on; acknowledge low straddles the end of busy
    assign busy_o = (cnt >= 1) && (cnt <= BUSY_CYC);
    assign ack_n_o = !((cnt > BUSY_CYC - ACK_CYC / 2) && (cnt <= BUSY_CYC + ACK_CYC / 2));
    always @(posedge clk_sys_i) begin
        strobe_d <= strobe_i;
        if (strobe_i && !strobe_d) begin
            if (cnt != 0) proto_err_o <= 1'b1;
            cnt <= 1;
            if (stable < pp_pkg::STROBE_MIN_CYC) proto_err_o <= 1'b1;
            byte_o <= pins_o;
        end else if (cnt != 0) begin
            cnt <= (cnt >= BUSY_CYC + ACK_CYC / 2) ? 0 : cnt + 1;
        end
        if (strobe_i && strobe_d && pins_o !== byte_o) proto_err_o <= 1'b1;
    end
endmodule : pp_printer_model

`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the printer port against a behavioural printer
`timescale 1ns/1ns
`default_nettype none

module testbench;
    localparam int INIT_CYC = 20;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [7:0] pins;
    logic [7:0] pp_data_o;
    logic pp_data_oe_o, pp_strobe_o, pp_autofeed_o, pp_init_o, pp_select_in_o, irq_o;
    logic pp_paper_end_i = 1'b0;
    logic pp_selected_i = 1'b1;
    logic pp_error_n_i = 1'b1;
    logic drive_en = 1'b0;
    logic [7:0] drive_val = 8'h5A;
    logic busy, ack_n, proto_err;
    logic [7:0] last_byte;
    logic [31:0] rd;
    int failures = 0;
    int num_checks = 0;
    int strobe_run = 0, strobe_w = 0, init_run = 0, init_w = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    pp_top #(.INIT_MIN_CYC(INIT_CYC)) pp_top_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .pp_data_i(pins), .pp_data_o(pp_data_o), .pp_data_oe_o(pp_data_oe_o),
        .pp_strobe_o(pp_strobe_o), .pp_autofeed_o(pp_autofeed_o), .pp_init_o(pp_init_o),
        .pp_select_in_o(pp_select_in_o), .pp_busy_i(busy), .pp_ack_n_i(ack_n),
        .pp_paper_end_i(pp_paper_end_i), .pp_selected_i(pp_selected_i),
        .pp_error_n_i(pp_error_n_i), .irq_o(irq_o));

    pp_printer_model pp_printer_model_inst (.clk_sys_i(clk_sys_i), .host_data_i(pp_data_o),
        .host_oe_i(pp_data_oe_o), .strobe_i(pp_strobe_o), .drive_en_i(drive_en),
        .drive_val_i(drive_val), .pins_o(pins), .busy_o(busy), .ack_n_o(ack_n),
        .byte_o(last_byte), .proto_err_o(proto_err));

    // Widths of the last strobe and initialize pulses, in clock cycles
    always @(posedge clk_sys_i) begin
        strobe_run <= pp_strobe_o ? strobe_run + 1 : 0;
        if (!pp_strobe_o && strobe_run != 0) strobe_w <= strobe_run;
        init_run <= pp_init_o ? init_run + 1 : 0;
        if (!pp_init_o && init_run != 0) init_w <= init_run;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    // One Avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [2:0] idx, input logic [7:0] d,
                       input logic [3:0] be);
        @(posedge clk_sys_i);
        avs_address_i <= {idx, 2'h0};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= {24'h000000, d};
        avs_byteenable_i <= be;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : bus

    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'hF);
    endtask : wr

    task automatic rdchk(input string name, input logic [2:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00, 4'hF);
        check(name, rd, exp);
    endtask : rdchk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : tick

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdchk("ctrl reset", pp_pkg::IDX_CTRL, 32'h00000004);
        rdchk("data reset", pp_pkg::IDX_DATA, 32'h00000000);
        rdchk("irq stat reset", pp_pkg::IDX_IRQ_STAT, 32'h00000000);
        rdchk("irq mask reset", pp_pkg::IDX_IRQ_MASK, 32'h00000000);
        check("oe reset", pp_data_oe_o, 1'b1);
        check("init reset", pp_init_o, 1'b0);
    endtask : t_reset

    task automatic t_ctrl();
        wr(pp_pkg::IDX_CTRL, 8'hEE);
        tick(1);
        rdchk("ctrl readback", pp_pkg::IDX_CTRL, 32'h0000000E);
        check("oe input mode", pp_data_oe_o, 1'b0);
        check("select in", pp_select_in_o, 1'b1);
        check("autofeed", pp_autofeed_o, 1'b1);
        check("init idle", pp_init_o, 1'b0);
        check("strobe idle", pp_strobe_o, 1'b0);
        @(posedge clk_sys_i);
        drive_en <= 1'b1;
        tick(2);
        rdchk("data input", pp_pkg::IDX_DATA, 32'h0000005A);
        drive_en <= 1'b0;
        wr(pp_pkg::IDX_CTRL, 8'h04);
        tick(1);
        check("oe output mode", pp_data_oe_o, 1'b1);
        check("select off", pp_select_in_o, 1'b0);
        check("autofeed off", pp_autofeed_o, 1'b0);
    endtask : t_ctrl

    task automatic t_data();
        wr(pp_pkg::IDX_DATA, 8'hA5);
        bus(1'b1, pp_pkg::IDX_DATA, 8'h5A, 4'hE);
        rdchk("data readback", pp_pkg::IDX_DATA, 32'h000000A5);
        tick(1);
        check("data pins", pins, 8'hA5);
        for (int i = 5; i < 8; i++) begin
            wr(i[2:0], 8'hFF);
            rdchk("unmapped", i[2:0], 32'h00000000);
        end
    endtask : t_data

    task automatic t_status();
        @(posedge clk_sys_i);
        pp_paper_end_i <= 1'b1;
        tick(3);
        rdchk("status paper", pp_pkg::IDX_STATUS, 32'h00000078);
        @(posedge clk_sys_i);
        pp_paper_end_i <= 1'b0;
        pp_selected_i <= 1'b0;
        tick(3);
        rdchk("status offline", pp_pkg::IDX_STATUS, 32'h00000048);
        @(posedge clk_sys_i);
        pp_selected_i <= 1'b1;
    endtask : t_status

    task automatic t_print(input logic en);
        wr(pp_pkg::IDX_DATA, 8'h3C);
        tick(pp_pkg::STROBE_MIN_CYC);
        wr(pp_pkg::IDX_IRQ_MASK, 8'h01);
        wr(pp_pkg::IDX_CTRL, {3'h0, en, 4'h5});
        wr(pp_pkg::IDX_CTRL, {3'h0, en, 4'h4});
        rdchk("status busy", pp_pkg::IDX_STATUS, 32'h000000D8);
        for (int i = 0; i < 3000 && ack_n !== 1'b0; i++) @(posedge clk_sys_i);
        bus(1'b0, pp_pkg::IDX_STATUS, 8'h00, 4'hF);
        check("status ack", rd[6], 1'b0);
        for (int i = 0; i < 3000 && ack_n !== 1'b1; i++) @(posedge clk_sys_i);
        tick(3);
        check("strobe width", strobe_w, pp_pkg::STROBE_MIN_CYC);
        check("byte taken", last_byte, 8'h3C);
        check("protocol", proto_err, 1'b0);
        check("irq level", irq_o, en);
        rdchk("irq stat", pp_pkg::IDX_IRQ_STAT, {31'h0, en});
        wr(pp_pkg::IDX_IRQ_STAT, 8'h01);
        tick(2);
        check("irq cleared", irq_o, 1'b0);
    endtask : t_print

    task automatic t_error();
        @(posedge clk_sys_i);
        pp_error_n_i <= 1'b0;
        tick(3);
        rdchk("status error", pp_pkg::IDX_STATUS, 32'h00000050);
        rdchk("irq stat error", pp_pkg::IDX_IRQ_STAT, 32'h00000002);
        check("irq masked", irq_o, 1'b0);
        wr(pp_pkg::IDX_IRQ_MASK, 8'h03);
        tick(2);
        check("irq unmasked", irq_o, 1'b1);
        wr(pp_pkg::IDX_IRQ_STAT, 8'h02);
        tick(2);
        check("irq error cleared", irq_o, 1'b0);
        @(posedge clk_sys_i);
        pp_error_n_i <= 1'b1;
    endtask : t_error

    task automatic t_init();
        wr(pp_pkg::IDX_CTRL, 8'h00);
        wr(pp_pkg::IDX_CTRL, 8'h04);
        tick(INIT_CYC + 10);
        check("init width", init_w >= INIT_CYC, 1'b1);
        check("init released", pp_init_o, 1'b0);
    endtask : t_init

    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset();
        t_ctrl();
        t_data();
        t_status();
        t_print(1'b1);
        t_print(1'b0);
        t_error();
        t_init();
        print_verdict();
    end

    // Whole run needs some 2400 cycles; allow a wide margin
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        print_verdict();
    end
endmodule : testbench

`default_nettype wire
